// ==== emi_pkg.sv ====
// Shared constants for the external memory bus interface
package emi_pkg;
  // APB register byte addresses
  localparam logic [7:0] EMI_MCU_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] EMI_EXT_CTRL_REG_A_OFS  = 8'h04;
  localparam logic [7:0] EMI_EXT_CTRL_REG_B_OFS  = 8'h08;
  localparam logic [7:0] EMI_ACCESS_ADDR_OFS     = 8'h0C;
  localparam logic [7:0] EMI_ACCESS_DATA_OFS     = 8'h10;
  localparam logic [7:0] EMI_ACCESS_CMD_OFS      = 8'h14;
  localparam logic [7:0] EMI_STATUS_OFS          = 8'h18;
  // Field positions
  localparam int EMI_ENABLE_BIT      = 7;
  localparam int EMI_UPPER_LO_BIT    = 6;
  localparam int EMI_LIMIT_LSB       = 4;
  localparam int EMI_LOWER_WAIT_LSB  = 2;
  localparam int EMI_UPPER_HI_BIT    = 1;
  localparam int EMI_KEEPER_BIT      = 7;
  // Reset values and writable bit masks
  localparam logic [7:0] EMI_MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] EMI_EXT_CTRL_A_RST  = 8'h00;
  localparam logic [7:0] EMI_EXT_CTRL_B_RST  = 8'h00;
  localparam logic [7:0] EMI_CTRL_A_RMASK    = 8'h7E;
  localparam logic [7:0] EMI_CTRL_B_RMASK    = 8'h87;
  // First external address
  localparam logic [15:0] EMI_INT_MEM_TOP = 16'h1100;
  // Wait selector codes
  localparam logic [1:0] EMI_WAIT_NONE  = 2'h0;
  localparam logic [1:0] EMI_WAIT_ONE   = 2'h1;
  localparam logic [1:0] EMI_WAIT_TWO   = 2'h2;
  localparam logic [1:0] EMI_WAIT_TWO_A = 2'h3;
  typedef enum logic [2:0] {
    EMI_IDLE, EMI_ADDR, EMI_STROBE, EMI_WAIT, EMI_TAIL, EMI_HOLD
  } emi_state_t;
endpackage

// ==== emi_ext_mem_if.sv ====
// External memory bus interface core with APB register slave
//
// Contract
// R01 - Low address and data share one bus
// R02 - High address byte, configurable bit count
// R03 - Enabled interface owns its pin directions
// R04 - Internal versus external decided from address
// R05 - Valid low address when strobe falls
// R06 - Latch strobe low during data phase
// R07 - Internal access never toggles read/write strobes
// R08 - Disabled: port pins, no wraparound; strobe pins still carry interface levels, PORT_G_OUT unused
// R09 - Four wait settings including none
// R10 - Two sectors with separate wait settings
// R11 - Keeper holds last level when released
// R12 - Port one bits enable bus pull-ups; code gives no pull-ups while the bus keeper is enabled
// R13 - No wait: extra strobe only if next
// R14 - One wait: extra strobe only if next
// R15 - Two wait: extra strobe only if next
// R16 - Two plus delay: strobe only if next
// R17 - Legacy mode hides extended control registers
// R18 - Legacy upper wait only none or one
// R19 - Legacy: fixed high bits, no sectors
// R20 - Legacy mode has no bus keeper
// R21 - Legacy: strobe pins output only
// R22 - External latch transparent high, holds low
// R23 - Enable bit switches pins to interface
// R24 - Wait code meaning per sector
// R25 - Sector limit code places boundary
// R26 - High mask frees top address pins
// R27 - Write drives data; read samples at rise
// R28 - Memory returns data before read rises
`timescale 1ns/100ps
module emi_ext_mem_if (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        LEGACY_MODE,
  input  wire logic        NEXT_IS_DATA_ACCESS,
  input  wire logic [7:0]  PORT_A_OUT,
  input  wire logic [7:0]  PORT_A_DIR,
  input  wire logic [7:0]  PORT_C_OUT,
  input  wire logic [7:0]  PORT_C_DIR,
  input  wire logic [2:0]  PORT_G_OUT,
  input  wire logic [2:0]  PORT_G_DIR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  AD_IN,
  output logic      [7:0]  AD_OUT,
  output logic      [7:0]  AD_OE,
  output logic      [7:0]  AD_PULLUP,
  output logic      [7:0]  AD_KEEPER,
  output logic      [7:0]  HIGH_ADDR_OUT,
  output logic      [7:0]  HIGH_ADDR_OE,
  output logic             ALE_OUT,
  output logic             RD_N_OUT,
  output logic             WR_N_OUT,
  output logic      [2:0]  STROBE_OE,
  output logic             INTERNAL_SEL,
  output logic             BUSY
);
  import emi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  mcu_control_reg;
  logic [7:0]  ext_ctrl_reg_a;
  logic [7:0]  ext_ctrl_reg_b;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  acc_rdata;
  logic        acc_write;
  logic        start;
  logic        ext_if_enable;
  logic        bus_keeper_enable;
  logic [1:0]  upper_sector_wait_sel;
  logic [1:0]  lower_wait_sel;
  logic [2:0]  sector_limit_sel;
  logic [2:0]  high_addr_mask;
  logic [1:0]  wait_sel;
  logic [3:0]  high_bits;
  logic        ext_regs_hit;
  logic        wr_go;
  logic        rd_go;
  emi_state_t  state;
  logic [1:0]  wait_cnt;
  logic        cyc_external;
  logic        cyc_write;
  logic [1:0]  cyc_wait;
  logic        drive_data;
  logic [7:0]  keeper_level;
  logic [1:0]  wait_load;
  logic        strobe_phase;
  logic        last_strobe;
  logic        next_rd_n;
  logic        next_wr_n;
  logic        addr_phase;
  logic        trailing_pulse;
  logic        next_ale;
  logic [7:0]  next_ad_out;

  ////////////////////////////////////////////////////////////////////////////
  // Legacy mode: extended registers read zero and take no writes
  assign ext_regs_hit = (PADDR == EMI_EXT_CTRL_REG_A_OFS) ||
                        (PADDR == EMI_EXT_CTRL_REG_B_OFS);
  assign wr_go = PSEL && PENABLE && PWRITE;
  assign rd_go = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mcu_control_reg <= EMI_MCU_CONTROL_RST;
    end else if (wr_go && PADDR == EMI_MCU_CONTROL_REG_OFS) begin
      mcu_control_reg <= PWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_ctrl_reg_a <= EMI_EXT_CTRL_A_RST;
      ext_ctrl_reg_b <= EMI_EXT_CTRL_B_RST;
    end else if (wr_go && ext_regs_hit && !LEGACY_MODE) begin  // [R17]
      if (PADDR == EMI_EXT_CTRL_REG_A_OFS) begin
        ext_ctrl_reg_a <= PWDATA[7:0] & EMI_CTRL_A_RMASK;
      end
      if (PADDR == EMI_EXT_CTRL_REG_B_OFS) begin
        ext_ctrl_reg_b <= PWDATA[7:0] & EMI_CTRL_B_RMASK;
      end
    end
  end

  // Access port: address and write data held for the sequencer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_addr <= 16'h0000;
    end else if (wr_go && PADDR == EMI_ACCESS_ADDR_OFS) begin
      acc_addr <= PWDATA[15:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_wdata <= 8'h00;
    end else if (wr_go && PADDR == EMI_ACCESS_DATA_OFS) begin
      acc_wdata <= PWDATA[7:0];
    end
  end

  // A write to the command word launches one data access
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_write <= 1'b0;
      start     <= 1'b0;
    end else begin
      start <= 1'b0;
      // Commands while busy are dropped; software polls the status word
      if (wr_go && PADDR == EMI_ACCESS_CMD_OFS && state == EMI_IDLE && !start) begin
        acc_write <= PWDATA[0];
        start     <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        EMI_MCU_CONTROL_REG_OFS: PRDATA <= {24'h000000, mcu_control_reg};
        EMI_EXT_CTRL_REG_A_OFS:  PRDATA <= LEGACY_MODE ? 32'h0 : {24'h0, ext_ctrl_reg_a};
        EMI_EXT_CTRL_REG_B_OFS:  PRDATA <= LEGACY_MODE ? 32'h0 : {24'h0, ext_ctrl_reg_b};
        EMI_ACCESS_ADDR_OFS:     PRDATA <= {16'h0000, acc_addr};
        EMI_ACCESS_DATA_OFS:     PRDATA <= {24'h000000, acc_rdata};
        EMI_STATUS_OFS:          PRDATA <= {30'h0, cyc_external, BUSY};
        default:                 PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ext_if_enable     = mcu_control_reg[EMI_ENABLE_BIT];  // [R23]
  assign bus_keeper_enable = !LEGACY_MODE && ext_ctrl_reg_b[EMI_KEEPER_BIT];  // [R20]
  // Legacy: upper high bit forced off, so only codes 00 and 01 remain
  assign upper_sector_wait_sel = {!LEGACY_MODE && ext_ctrl_reg_a[EMI_UPPER_HI_BIT],
                                  mcu_control_reg[EMI_UPPER_LO_BIT]};  // [R18]
  assign lower_wait_sel   = ext_ctrl_reg_a[EMI_LOWER_WAIT_LSB +: 2];
  assign sector_limit_sel = LEGACY_MODE ? 3'h0 : ext_ctrl_reg_a[EMI_LIMIT_LSB +: 3];  // [R19]
  assign high_addr_mask   = LEGACY_MODE ? 3'h0 : ext_ctrl_reg_b[2:0];  // [R19]

  // Boundary at limit code times 0x2000; code zero means upper only
  always_comb begin
    if (sector_limit_sel != 3'h0 && acc_addr[15:13] < sector_limit_sel) begin
      wait_sel = lower_wait_sel;  // [R10] [R25]
    end else begin
      wait_sel = upper_sector_wait_sel;  // [R24]
    end
  end

  assign high_bits = 4'h8 - {1'b0, high_addr_mask};  // [R26]
  assign INTERNAL_SEL = (acc_addr < EMI_INT_MEM_TOP);

  ////////////////////////////////////////////////////////////////////////////
  // Wait cycles loaded on leaving the strobe state
  always_comb begin
    unique case (cyc_wait)
      EMI_WAIT_NONE:  wait_load = 2'h0;
      EMI_WAIT_ONE:   wait_load = 2'h1;
      EMI_WAIT_TWO:   wait_load = 2'h2;
      // Extra address delay comes from the hold state
      EMI_WAIT_TWO_A: wait_load = 2'h2;
    endcase
  end

  // Access sequencer; one state per system clock period
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state        <= EMI_IDLE;
      wait_cnt     <= 2'h0;
      cyc_external <= 1'b0;
      cyc_write    <= 1'b0;
      cyc_wait     <= EMI_WAIT_NONE;
    end else begin
      unique case (state)
        EMI_IDLE: if (start) begin
          // Disabled interface ignores external addresses, no aliasing
          cyc_external <= ext_if_enable && !INTERNAL_SEL;  // [R04] [R08]
          cyc_write    <= acc_write;
          cyc_wait     <= wait_sel;  // [R09]
          state        <= EMI_ADDR;
        end
        EMI_ADDR:   state <= EMI_STROBE;
        EMI_STROBE: begin
          wait_cnt <= wait_load;  // [R24]
          state    <= (cyc_wait == EMI_WAIT_NONE) ? EMI_TAIL : EMI_WAIT;
        end
        EMI_WAIT: begin
          wait_cnt <= wait_cnt - 2'h1;
          if (wait_cnt == 2'h1) begin
            state <= EMI_TAIL;
          end
        end
        EMI_TAIL: state <= (cyc_wait == EMI_WAIT_TWO_A) ? EMI_HOLD : EMI_IDLE;
        EMI_HOLD: state <= EMI_IDLE;
        default:  state <= EMI_IDLE;
      endcase
    end
  end

  assign BUSY = (state != EMI_IDLE) || start;

  // Latch strobe high only in address phase; trailing pulse on demand
  always_comb begin
    addr_phase     = (state == EMI_IDLE) && start;
    // Trailing pulse only when the next instruction touches data memory
    trailing_pulse = NEXT_IS_DATA_ACCESS &&
                     ((state == EMI_TAIL && cyc_wait != EMI_WAIT_TWO_A) ||
                      state == EMI_HOLD);  // [R13] [R14] [R15] [R16]
    next_ale       = ext_if_enable && (addr_phase || trailing_pulse);  // [R05] [R06]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALE_OUT <= 1'b0;
    end else begin
      ALE_OUT <= next_ale;
    end
  end

  // Read strobe low through strobe and wait cycles; write strobe one cycle later, low in the tail with no wait
  always_comb begin
    strobe_phase = (state == EMI_STROBE && cyc_wait != EMI_WAIT_NONE) ||
                   (state == EMI_WAIT && wait_cnt != 2'h1);
    last_strobe  = (state == EMI_STROBE && cyc_wait == EMI_WAIT_NONE) ||
                   (state == EMI_WAIT && wait_cnt == 2'h1);
    next_rd_n    = !(cyc_external && !cyc_write &&
                     (state == EMI_ADDR || strobe_phase));  // [R07] [R27]
    next_wr_n    = !(cyc_external && cyc_write &&
                     (state == EMI_STROBE || strobe_phase));  // [R07] [R27]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_N_OUT <= 1'b1;
    end else begin
      RD_N_OUT <= next_rd_n;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WR_N_OUT <= 1'b1;
    end else begin
      WR_N_OUT <= next_wr_n;
    end
  end

  // Read data captured on the edge where the read strobe rises
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_rdata <= 8'h00;
    end else if (cyc_external && !cyc_write && !RD_N_OUT && last_strobe) begin
      acc_rdata <= AD_IN;  // [R27] [R28]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus drivers and pin ownership
  assign drive_data = cyc_write &&
                      (state == EMI_STROBE || state == EMI_WAIT || state == EMI_TAIL);

  // Write data waits until the latch strobe has fallen: the address stays valid at that edge
  always_comb begin
    next_ad_out = AD_OUT;
    if (!ext_if_enable) begin
      next_ad_out = PORT_A_OUT;  // [R08]
    end else if (addr_phase) begin
      next_ad_out = acc_addr[7:0];  // [R01] [R05]
    end else if (drive_data) begin
      next_ad_out = acc_wdata;  // [R01] [R27]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AD_OUT <= 8'h00;
    end else begin
      AD_OUT <= next_ad_out;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HIGH_ADDR_OUT <= 8'h00;
    end else if (!ext_if_enable) begin
      HIGH_ADDR_OUT <= PORT_C_OUT;  // [R08]
    end else begin
      for (int i = 0; i < 8; i++) begin
        HIGH_ADDR_OUT[i] <= (i < int'(high_bits)) ? acc_addr[8 + i] : PORT_C_OUT[i];  // [R02]
      end
    end
  end

  always_comb begin
    // Address phase drives, read data phase releases
    if (ext_if_enable) begin
      AD_OE = (state == EMI_ADDR || drive_data) ? 8'hFF : 8'h00;  // [R03] [R27]
      for (int i = 0; i < 8; i++) begin
        HIGH_ADDR_OE[i] = (i < int'(high_bits)) ? 1'b1 : PORT_C_DIR[i];  // [R03] [R26]
      end
      STROBE_OE = 3'h7;  // [R03]
    end else begin
      AD_OE        = PORT_A_DIR;  // [R08]
      HIGH_ADDR_OE = PORT_C_DIR;
      // Legacy pins stay outputs always
      STROBE_OE    = LEGACY_MODE ? 3'h7 : PORT_G_DIR;  // [R21]
    end
  end

  // Keeper remembers the last seen level; drives only while released
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      keeper_level <= 8'h00;
    end else begin
      keeper_level <= AD_IN;
    end
  end

  assign AD_KEEPER = bus_keeper_enable ? (keeper_level & ~AD_OE) : 8'h00;  // [R11]
  // Pull-up request only on released lines with port bit one
  assign AD_PULLUP = PORT_A_OUT & ~AD_OE & {8{!bus_keeper_enable}};  // [R12]

  // Strobe port levels are unused; the strobe pins always carry the interface levels
  logic unused_g;
  assign unused_g = ^PORT_G_OUT;
endmodule

// ==== emi_props.sv ====
// Checker of external memory bus strobe and pin behaviour
`timescale 1ns/100ps
module emi_props (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       LEGACY_MODE,
  input wire logic [7:0] AD_OE,
  input wire logic [7:0] AD_PULLUP,
  input wire logic [7:0] AD_KEEPER,
  input wire logic       ALE_OUT,
  input wire logic       RD_N_OUT,
  input wire logic       WR_N_OUT,
  input wire logic [2:0] STROBE_OE,
  input wire logic       INTERNAL_SEL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////
  property p_int_quiet; INTERNAL_SEL |-> RD_N_OUT && WR_N_OUT; endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("strobe during internal access");
  property p_ale_rd; !RD_N_OUT |-> !ALE_OUT; endproperty
  a_ale_rd: assert property (p_ale_rd)
    else $error("latch strobe high during read");
  property p_ale_wr; !WR_N_OUT |-> !ALE_OUT; endproperty
  a_ale_wr: assert property (p_ale_wr)
    else $error("latch strobe high during write");
  property p_wr_drive; !WR_N_OUT |-> AD_OE == 8'hFF; endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("bus not driven during write");
  property p_rd_rel; !RD_N_OUT |-> AD_OE == 8'h00; endproperty
  a_rd_rel: assert property (p_rd_rel)
    else $error("bus driven during read");
  property p_rd_len; $fell(RD_N_OUT) |-> ##[1:3] $rose(RD_N_OUT); endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe too long");
  property p_pull_rel; (AD_PULLUP & AD_OE) == 8'h00; endproperty
  a_pull_rel: assert property (p_pull_rel)
    else $error("pull-up on driven line");
  property p_keep_leg; LEGACY_MODE |-> AD_KEEPER == 8'h00; endproperty
  a_keep_leg: assert property (p_keep_leg)
    else $error("keeper active in legacy mode");
  property p_strb_out; LEGACY_MODE && !RD_N_OUT |-> STROBE_OE == 3'h7; endproperty
  a_strb_out: assert property (p_strb_out)
    else $error("strobe pin not output in legacy");
  c_rd: cover property ($fell(RD_N_OUT));
  c_wr: cover property ($fell(WR_N_OUT));
  c_leg: cover property (LEGACY_MODE && !RD_N_OUT);
endmodule
bind emi_ext_mem_if emi_props emi_props_i (.SYS_CLK, .RST_N, .LEGACY_MODE, .AD_OE,
  .AD_PULLUP, .AD_KEEPER, .ALE_OUT, .RD_N_OUT, .WR_N_OUT, .STROBE_OE, .INTERNAL_SEL);

// ==== emi_sram_model.sv ====
// Behavioural external SRAM behind a clock-sampled address latch
`timescale 1ns/100ps
module emi_sram_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] ad,
  input  wire logic [7:0] hi,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic      [7:0] drv,
  output logic            oe
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  // Gate sampled on the clock: the bus turns at the very edge the strobe falls
  always @(posedge sys_clk) if (ale) lat <= ad;
  // Stored on the clock while the write strobe is low; no strobe-edge race
  always @(posedge sys_clk) if (!wr_n) mem[{hi, lat}] <= ad;
  assign oe  = !rd_n;
  assign drv = mem[{hi, lat}];
endmodule

// ==== tb_emi_ext_mem_if.sv ====
// Testbench of the external memory bus interface
`timescale 1ns/100ps
module tb_emi_ext_mem_if;
  import emi_pkg::*;
  logic SYS_CLK = 0, RST_N = 0, LEGACY_MODE = 0, NEXT_IS_DATA_ACCESS = 0;
  logic PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, ALE_OUT, RD_N_OUT, WR_N_OUT;
  logic BUSY, moe, ale_q;
  logic [7:0] PADDR = 0, PORT_A_OUT = 0, PORT_A_DIR = 0, PORT_C_DIR = 0, ad_last = 0;
  logic [7:0] AD_OUT, AD_OE, AD_PULLUP, HIGH_ADDR_OUT, HIGH_ADDR_OE, ad_line, mdrv;
  logic [31:0] PWDATA = 0, PRDATA, r;
  int miscompares = 0, compares = 0, cyc = 0, nrd, nwr, nale, k;
  emi_ext_mem_if emi_ext_mem_if_i (.SYS_CLK, .RST_N, .LEGACY_MODE, .NEXT_IS_DATA_ACCESS,
    .PORT_A_OUT, .PORT_A_DIR, .PORT_C_OUT(8'h00), .PORT_C_DIR, .PORT_G_OUT(3'h0),
    .PORT_G_DIR(3'h0), .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .AD_IN(ad_line), .AD_OUT, .AD_OE, .AD_PULLUP, .AD_KEEPER(), .HIGH_ADDR_OUT,
    .HIGH_ADDR_OE, .ALE_OUT, .RD_N_OUT, .WR_N_OUT, .STROBE_OE(), .INTERNAL_SEL(), .BUSY);
  emi_sram_model emi_sram_model_i (.sys_clk(SYS_CLK), .ad(ad_line), .hi(HIGH_ADDR_OUT),
    .ale(ALE_OUT), .rd_n(RD_N_OUT), .wr_n(WR_N_OUT), .drv(mdrv), .oe(moe));
  always #5 SYS_CLK = ~SYS_CLK;
  // Released line floats to inverse of last level unless pulled up
  assign ad_line = (AD_OE & AD_OUT) | (~AD_OE & (moe ? mdrv : AD_PULLUP | ~ad_last));
  always @(posedge SYS_CLK) ad_last <= ad_line;
  ////////////////////////////////////////////////////////////////
  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(name, exp, r);
  endtask
  // Counts strobe cycles until idle plus a short tail for late pulses
  task acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    apb(1, EMI_ACCESS_ADDR_OFS, {16'h0, a});
    apb(1, EMI_ACCESS_DATA_OFS, {24'h0, d});
    apb(1, EMI_ACCESS_CMD_OFS, {31'h0, w});
    nrd = 0;
    nwr = 0;
    nale = 0;
    k = 0;
    ale_q = ALE_OUT;
    do begin
      @(posedge SYS_CLK);
      nrd += int'(RD_N_OUT === 1'b0);
      nwr += int'(WR_N_OUT === 1'b0);
      nale += int'(ALE_OUT === 1'b1 && ale_q !== 1'b1);
      ale_q = ALE_OUT;
      if (BUSY !== 1'b1) k++;
    end while (k < 3);
  endtask
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1;
    rdchk("mcu_rst", EMI_MCU_CONTROL_REG_OFS, 0);
    apb(1, EMI_EXT_CTRL_REG_A_OFS, 32'hFF);
    rdchk("ctrl_a", EMI_EXT_CTRL_REG_A_OFS, 32'h7E);
    apb(1, EMI_EXT_CTRL_REG_B_OFS, 32'hFF);
    rdchk("ctrl_b", EMI_EXT_CTRL_REG_B_OFS, 32'h87);
    rdchk("unmapped", 8'h1C, 0);
    apb(1, EMI_MCU_CONTROL_REG_OFS, 32'h80);
    apb(1, EMI_EXT_CTRL_REG_B_OFS, 32'h03);
    @(posedge SYS_CLK);
    chk("hi_oe_mask", 8'h1F, HIGH_ADDR_OE);
    apb(1, EMI_EXT_CTRL_REG_B_OFS, 32'h00);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      apb(1, EMI_MCU_CONTROL_REG_OFS, 32'h80 | (c & 1) << 6);
      apb(1, EMI_EXT_CTRL_REG_A_OFS, c & 2);
      NEXT_IS_DATA_ACCESS <= c[0];
      acc(16'h8000 + c, 1, 8'h5A + c);
      chk("wr_seen", 1, int'(nwr > 0));
      acc(16'h8000 + c, 0, 8'h00);
      chk("rd_len", 1 + (c > 1 ? 2 : c), nrd);
      chk("ale_cnt", 1 + c[0], nale);
      rdchk("rd_data", EMI_ACCESS_DATA_OFS, 8'h5A + c);
    end
    $display("test wait states done");
    apb(1, EMI_MCU_CONTROL_REG_OFS, 32'h80);
    apb(1, EMI_EXT_CTRL_REG_A_OFS, 32'h12);
    acc(16'h1FFF, 0, 8'h00);
    chk("lower_len", 1, nrd);
    acc(16'h2000, 0, 8'h00);
    chk("upper_len", 3, nrd);
    acc(16'h10FF, 0, 8'h00);
    chk("int_rd", 0, nrd);
    $display("test sectors done");
    LEGACY_MODE <= 1;
    apb(1, EMI_EXT_CTRL_REG_A_OFS, 32'hFF);
    rdchk("leg_a", EMI_EXT_CTRL_REG_A_OFS, 0);
    rdchk("leg_b", EMI_EXT_CTRL_REG_B_OFS, 0);
    apb(1, EMI_MCU_CONTROL_REG_OFS, 32'hC0);
    acc(16'h2000, 0, 8'h00);
    chk("leg_len", 2, nrd);
    $display("test legacy done");
    LEGACY_MODE <= 0;
    apb(1, EMI_MCU_CONTROL_REG_OFS, 32'h00);
    PORT_A_OUT <= 8'hFF;
    PORT_A_DIR <= 8'h0F;
    acc(16'h9000, 0, 8'h00);
    chk("dis_rd", 0, nrd);
    chk("dis_oe", 8'h0F, AD_OE);
    chk("dis_pull", 8'hF0, AD_PULLUP);
    $display("test disabled done");
    close_out;
  end
endmodule
